/* design/gxf_pkg.sv */
package gxf_pkg;
    // ========================================================
    // Register map
    localparam logic [7:0] ADDR_ENTRY_THR = 8'hA0;
    localparam logic [7:0] ADDR_EXIT_THR = 8'hA1;
    localparam logic [7:0] ADDR_CONFIG_ONE = 8'hA2;
    localparam logic [7:0] RST_ENTRY_THR = 8'h00;
    localparam logic [7:0] RST_EXIT_THR = 8'h00;
    localparam logic [7:0] RST_CONFIG_ONE = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // Field positions in the first configuration register
    localparam int FIFO_SEL_LSB = 6;
    localparam int MASK_LSB = 2;
    localparam int PERS_LSB = 0;
    // Mask bit positions: one detector per bit
    localparam int MASK_RIGHT = 0;
    localparam int MASK_LEFT = 1;
    localparam int MASK_DOWN = 2;
    localparam int MASK_UP = 3;
    // Dataset counts per FIFO level selection
    localparam logic [5:0] FIFO_LVL_0 = 6'h01;
    localparam logic [5:0] FIFO_LVL_1 = 6'h04;
    localparam logic [5:0] FIFO_LVL_2 = 6'h08;
    localparam logic [5:0] FIFO_LVL_3 = 6'h10;
    // Consecutive gesture-end occurrences per persistence selection
    localparam logic [2:0] PERS_CNT_0 = 3'h1;
    localparam logic [2:0] PERS_CNT_1 = 3'h2;
    localparam logic [2:0] PERS_CNT_2 = 3'h4;
    localparam logic [2:0] PERS_CNT_3 = 3'h7;
    localparam logic [7:0] EXIT_DISABLED = 8'h00;

    // ========================================================
    // Types
    typedef enum logic [1:0] {
        GXF_IDLE = 2'h0,
        GXF_ACTIVE = 2'h1,
        GXF_EXIT = 2'h3
    } gxf_state_e;

    typedef struct packed {
        logic [7:0] up;
        logic [7:0] down;
        logic [7:0] left;
        logic [7:0] right;
    } gxf_dirs_s;

    typedef struct packed {
        logic [1:0] fifo_irq_level_sel;
        logic [3:0] exit_detector_mask;
        logic [1:0] exit_persistence_sel;
    } gxf_cfg_one_s;
endpackage : gxf_pkg

/* design/gxf_exit_sum.sv */
// ========================================================
// Masked sum of the four directional detector samples
module gxf_exit_sum #(
    parameter int DATA_W = 8
) (
    input wire logic [DATA_W-1:0] up,
    input wire logic [DATA_W-1:0] down,
    input wire logic [DATA_W-1:0] left,
    input wire logic [DATA_W-1:0] right,
    input wire logic [3:0] mask,
    output logic [DATA_W+1:0] sum
);
    if (DATA_W < 1 || DATA_W > 16) begin : g_bad_width
        $error("gxf_exit_sum: DATA_W out of range");
    end

    // Two spare bits keep the four-way sum from wrapping
    always_comb begin
        sum = '0;
        if (!mask[gxf_pkg::MASK_RIGHT]) begin // R5
            sum = sum + {2'b00, right};
        end
        if (!mask[gxf_pkg::MASK_LEFT]) begin // R5
            sum = sum + {2'b00, left};
        end
        if (!mask[gxf_pkg::MASK_DOWN]) begin // R5
            sum = sum + {2'b00, down};
        end
        if (!mask[gxf_pkg::MASK_UP]) begin // R5
            sum = sum + {2'b00, up};
        end
    end
endmodule : gxf_exit_sum

/* design/gxf_top.sv */
// Summary of operation
// [R1] The masked sum of the direction samples is compared with the 8-bit exit threshold to find a gesture end.
// [R2] An exit threshold of zero never ends a gesture; only a software clear of the active bit or dropping the gesture enable does.
// [R3] The FIFO level select in bits 7:6 is compared with the stored dataset count and raises the interrupt if enabled.
// [R4] Level select 0, 1, 2, 3 fires at 1, 4, 8, 16 datasets.
// [R5] Exit mask bits 5:2 drop right, left, down, up from the sum, one per bit, combining freely.
// [R6] Mask zero sums all four detectors and mask all ones sums none.
// [R7] Persistence bits 1:0 exit on the 1st, 2nd, 4th or 7th consecutive gesture end.
// [R8] The consecutive end counter clears on any valid gesture cycle without an end and on entry.
// [R9] Entry happens when the proximity result reaches the entry threshold, with no persistence filter.
module gxf_top #(
    parameter int DATA_W = 8,
    parameter int FIFO_W = 6
) (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic GESTURE_EN,
    input wire logic ACTIVE_CLR,
    input wire logic PROX_VALID,
    input wire logic [7:0] PROX_RESULT,
    input wire logic CYCLE_VALID,
    input wire gxf_pkg::gxf_dirs_s DIR_SAMPLE,
    input wire logic [FIFO_W-1:0] FIFO_LEVEL,
    input wire logic IRQ_EN,
    output logic GESTURE_ACTIVE,
    output logic EXIT_PULSE,
    output logic FIFO_IRQ,
    output logic [2:0] EXIT_COUNT
);
    if (DATA_W != 8 || FIFO_W < 5 || FIFO_W > 8) begin : g_bad_param
        $error("gxf_top: DATA_W must be 8 and FIFO_W within 5..8");
    end

    // ========================================================
    // Configuration registers
    logic [7:0] entry_threshold_value;
    logic [7:0] exit_threshold_value;
    gxf_pkg::gxf_cfg_one_s cfg;
    logic [7:0] next_entry_thr;
    logic [7:0] next_exit_thr;
    gxf_pkg::gxf_cfg_one_s next_cfg;
    logic [7:0] next_rdata;

    // Writes land in one cycle; reads return the addressed word next cycle
    always_comb begin
        next_entry_thr = entry_threshold_value;
        next_exit_thr = exit_threshold_value;
        next_cfg = cfg;
        if (REG_WR && REG_ADDR == gxf_pkg::ADDR_ENTRY_THR) begin
            next_entry_thr = REG_WDATA;
        end
        if (REG_WR && REG_ADDR == gxf_pkg::ADDR_EXIT_THR) begin
            next_exit_thr = REG_WDATA;
        end
        if (REG_WR && REG_ADDR == gxf_pkg::ADDR_CONFIG_ONE) begin
            next_cfg = gxf_pkg::gxf_cfg_one_s'(REG_WDATA);
        end
        case (REG_ADDR)
            gxf_pkg::ADDR_ENTRY_THR: next_rdata = entry_threshold_value;
            gxf_pkg::ADDR_EXIT_THR: next_rdata = exit_threshold_value;
            gxf_pkg::ADDR_CONFIG_ONE: next_rdata = 8'(cfg);
            default: next_rdata = gxf_pkg::UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            entry_threshold_value <= gxf_pkg::RST_ENTRY_THR;
            exit_threshold_value <= gxf_pkg::RST_EXIT_THR;
            cfg <= gxf_pkg::gxf_cfg_one_s'(gxf_pkg::RST_CONFIG_ONE);
            REG_RDATA <= gxf_pkg::UNMAPPED_READ;
        end else begin
            entry_threshold_value <= next_entry_thr;
            exit_threshold_value <= next_exit_thr;
            cfg <= next_cfg;
            REG_RDATA <= next_rdata;
        end
    end

    // ========================================================
    // Exit sum and gesture-end decision
    logic [DATA_W+1:0] exit_compare_level;
    logic gesture_end;
    logic [2:0] pers_need;

    gxf_exit_sum #(
        .DATA_W(DATA_W)
    ) u_sum (
        .up(DIR_SAMPLE.up),
        .down(DIR_SAMPLE.down),
        .left(DIR_SAMPLE.left),
        .right(DIR_SAMPLE.right),
        .mask(cfg.exit_detector_mask),
        .sum(exit_compare_level)
    );

    // End means the unmasked energy fell below the threshold
    always_comb begin
        gesture_end = 1'b0;
        if (exit_threshold_value != gxf_pkg::EXIT_DISABLED) begin // R2
            gesture_end = exit_compare_level <
                {2'b00, exit_threshold_value}; // R1
        end
        case (cfg.exit_persistence_sel) // R7
            2'h0: pers_need = gxf_pkg::PERS_CNT_0;
            2'h1: pers_need = gxf_pkg::PERS_CNT_1;
            2'h2: pers_need = gxf_pkg::PERS_CNT_2;
            2'h3: pers_need = gxf_pkg::PERS_CNT_3;
            default: pers_need = gxf_pkg::PERS_CNT_0;
        endcase
    end

    // ========================================================
    // Gesture state machine
    gxf_pkg::gxf_state_e state;
    gxf_pkg::gxf_state_e next_state;
    logic [2:0] next_count;
    logic next_active;
    logic next_exit_pulse;

    // A software clear wins over everything else while a gesture runs
    always_comb begin
        next_state = state;
        next_count = EXIT_COUNT;
        next_active = GESTURE_ACTIVE;
        next_exit_pulse = 1'b0;
        case (state)
            gxf_pkg::GXF_IDLE: begin
                next_count = 3'h0;
                if (GESTURE_EN && PROX_VALID &&
                        PROX_RESULT >= entry_threshold_value) begin // R9
                    next_state = gxf_pkg::GXF_ACTIVE;
                    next_active = 1'b1;
                    next_count = 3'h0; // R8
                end
            end
            gxf_pkg::GXF_ACTIVE: begin
                if (ACTIVE_CLR || !GESTURE_EN) begin // R2
                    next_state = gxf_pkg::GXF_IDLE;
                    next_active = 1'b0;
                    next_count = 3'h0;
                end else if (CYCLE_VALID) begin
                    if (!gesture_end) begin
                        next_count = 3'h0; // R8
                    end else if (EXIT_COUNT + 3'h1 >= pers_need) begin // R7
                        next_state = gxf_pkg::GXF_EXIT;
                        next_active = 1'b0;
                        next_exit_pulse = 1'b1;
                        next_count = EXIT_COUNT + 3'h1;
                    end else begin
                        next_count = EXIT_COUNT + 3'h1;
                    end
                end
            end
            gxf_pkg::GXF_EXIT: begin
                // One idle cycle stops a still-near target re-entering at once
                next_state = gxf_pkg::GXF_IDLE;
                next_count = 3'h0;
            end
            default: begin
                next_state = gxf_pkg::GXF_IDLE;
                next_active = 1'b0;
                next_count = 3'h0;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            state <= gxf_pkg::GXF_IDLE;
            EXIT_COUNT <= 3'h0;
            GESTURE_ACTIVE <= 1'b0;
            EXIT_PULSE <= 1'b0;
        end else begin
            state <= next_state;
            EXIT_COUNT <= next_count;
            GESTURE_ACTIVE <= next_active;
            EXIT_PULSE <= next_exit_pulse;
        end
    end

    // ========================================================
    // FIFO level interrupt
    logic [FIFO_W-1:0] fifo_need;
    logic next_irq;

    // Level driven: stays up while the FIFO holds enough datasets
    always_comb begin
        case (cfg.fifo_irq_level_sel) // R4
            2'h0: fifo_need = FIFO_W'(gxf_pkg::FIFO_LVL_0);
            2'h1: fifo_need = FIFO_W'(gxf_pkg::FIFO_LVL_1);
            2'h2: fifo_need = FIFO_W'(gxf_pkg::FIFO_LVL_2);
            2'h3: fifo_need = FIFO_W'(gxf_pkg::FIFO_LVL_3);
            default: fifo_need = FIFO_W'(gxf_pkg::FIFO_LVL_0);
        endcase
        next_irq = IRQ_EN && (FIFO_LEVEL >= fifo_need); // R3
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            FIFO_IRQ <= 1'b0;
        end else begin
            FIFO_IRQ <= next_irq;
        end
    end

    // ========================================================
    // Checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);

    zero_thr_hold_a: assert property ( // R2
        GESTURE_ACTIVE && exit_threshold_value == 8'h00 && !ACTIVE_CLR &&
        GESTURE_EN |=> GESTURE_ACTIVE
    ) else $error("gesture left with exit threshold zero");

    end_compare_a: assert property ( // R1
        state == gxf_pkg::GXF_ACTIVE && CYCLE_VALID && !ACTIVE_CLR &&
        GESTURE_EN && exit_threshold_value != 8'h00 &&
        exit_compare_level >= {2'b00, exit_threshold_value}
        |=> EXIT_COUNT == 3'h0 && !EXIT_PULSE
    ) else $error("non-end cycle counted as gesture end");

    mask_all_a: assert property ( // R6
        cfg.exit_detector_mask == 4'hf |-> exit_compare_level == '0
    ) else $error("fully masked sum not zero");

    mask_none_a: assert property ( // R6
        cfg.exit_detector_mask == 4'h0 |-> exit_compare_level ==
        10'(DIR_SAMPLE.up) + 10'(DIR_SAMPLE.down) +
        10'(DIR_SAMPLE.left) + 10'(DIR_SAMPLE.right)
    ) else $error("unmasked sum wrong");

    mask_right_a: assert property ( // R5
        cfg.exit_detector_mask == 4'h1 |-> exit_compare_level ==
        10'(DIR_SAMPLE.up) + 10'(DIR_SAMPLE.down) + 10'(DIR_SAMPLE.left)
    ) else $error("right detector not masked");

    persist_exit_a: assert property ( // R7
        EXIT_PULSE |-> $past(EXIT_COUNT) + 3'h1 == EXIT_COUNT &&
        EXIT_COUNT >= $past(pers_need) ##1 !GESTURE_ACTIVE
    ) else $error("exit not at selected occurrence");

    count_clear_a: assert property ( // R8
        $rose(GESTURE_ACTIVE) |-> EXIT_COUNT == 3'h0
    ) else $error("end counter not cleared on entry");

    entry_a: assert property ( // R9
        state == gxf_pkg::GXF_IDLE && GESTURE_EN && PROX_VALID &&
        PROX_RESULT >= entry_threshold_value |=> GESTURE_ACTIVE
    ) else $error("entry missed");

    fifo_irq_a: assert property ( // R3
        IRQ_EN && FIFO_LEVEL >= FIFO_W'(8) && cfg.fifo_irq_level_sel == 2'h2
        |=> FIFO_IRQ
    ) else $error("fifo interrupt missed at eight");

    fifo_quiet_a: assert property ( // R4
        cfg.fifo_irq_level_sel == 2'h3 && FIFO_LEVEL < FIFO_W'(16)
        |=> !FIFO_IRQ
    ) else $error("fifo interrupt early at sixteen");

    exit_seven_c: cover property (
        cfg.exit_persistence_sel == 2'h3 && EXIT_PULSE
    );
    sw_clear_c: cover property (
        GESTURE_ACTIVE && ACTIVE_CLR ##1 !GESTURE_ACTIVE
    );
    fifo_irq_c: cover property ($rose(FIFO_IRQ));
    masked_exit_c: cover property (
        EXIT_PULSE && cfg.exit_detector_mask == 4'h6
    );
endmodule : gxf_top

/* verification/gxf_host_model.sv */
// ========================================================
// Host side of the register bus: single-byte writes and reads
module gxf_host_model (
    input wire logic clk,
    output logic wr,
    output logic [7:0] addr,
    output logic [7:0] wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus starts idle
    initial begin
        wr = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end

    // One-cycle strobe, called just after an edge, returns just after one
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
        wr = 1'b0;
        wdata = ~d; // Stale data is not left on the bus
    endtask : put

    // Two edges so the registered read data has surely settled
    task automatic look(input logic [7:0] a);
        addr = a;
        @(posedge clk);
        @(posedge clk);
        #1;
    endtask : look
endmodule : gxf_host_model

/* verification/tb_top.sv */
// ========================================================
// Self-checking bench with an integer model of the exit filter
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk, srst, reg_wr, gesture_en, active_clr, prox_valid;
    logic cycle_valid, irq_en, gesture_active, exit_pulse, fifo_irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, prox_result;
    logic [5:0] fifo_level;
    logic [2:0] exit_count;
    gxf_pkg::gxf_dirs_s dir_sample;
    int error_cnt = 0;
    int samples_checked = 0;
    int m_active = 0;
    int m_cnt = 0;
    int m_entry = 0;
    int m_thr = 0;
    logic [7:0] m_cfg = 8'h00;
    int pers_need[4] = '{1, 2, 4, 7};
    int fifo_need[4] = '{1, 4, 8, 16};

    gxf_top u_dut (.SYS_CLK(sys_clk), .SRST(srst), .REG_WR(reg_wr),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .GESTURE_EN(gesture_en), .ACTIVE_CLR(active_clr),
        .PROX_VALID(prox_valid), .PROX_RESULT(prox_result),
        .CYCLE_VALID(cycle_valid), .DIR_SAMPLE(dir_sample),
        .FIFO_LEVEL(fifo_level), .IRQ_EN(irq_en),
        .GESTURE_ACTIVE(gesture_active), .EXIT_PULSE(exit_pulse),
        .FIFO_IRQ(fifo_irq), .EXIT_COUNT(exit_count));
    gxf_host_model u_host (.clk(sys_clk), .wr(reg_wr), .addr(reg_addr),
        .wdata(reg_wdata));

    // 250 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // ========================================================
    // Helpers
    task automatic chk(input logic [7:0] got, input int exp);
        samples_checked++;
        if (got !== 8'(exp)) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                8'(exp));
        end
    endtask : chk

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask : tick

    // Write, then read back; unmapped places read as zero
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        int exp;
        exp = d;
        u_host.put(a, d);
        case (a)
            gxf_pkg::ADDR_ENTRY_THR: m_entry = d;
            gxf_pkg::ADDR_EXIT_THR: m_thr = d;
            gxf_pkg::ADDR_CONFIG_ONE: m_cfg = d;
            default: exp = 0;
        endcase
        u_host.look(a);
        chk(reg_rdata, exp);
    endtask : wreg

    task automatic enter(input logic [7:0] p);
        prox_valid = 1'b1;
        prox_result = p;
        tick();
        prox_valid = 1'b0;
        prox_result = ~p;
        if (m_active == 0 && gesture_en && p >= m_entry) begin
            m_active = 1;
            m_cnt = 0;
        end
        chk(gesture_active, m_active);
        chk(exit_count, m_cnt);
    endtask : enter

    // One gesture cycle against the model; follows an exit back to idle
    task automatic gcycle(input logic [31:0] s);
        int sum;
        int hit;
        sum = 0;
        for (int i = 0; i < 4; i++) begin
            if (!m_cfg[gxf_pkg::MASK_LSB + i]) sum += s[8*i +: 8];
        end
        hit = (m_thr != 0 && sum < m_thr);
        cycle_valid = 1'b1;
        dir_sample = s;
        tick();
        cycle_valid = 1'b0;
        dir_sample = ~s;
        m_cnt = hit ? m_cnt + 1 : 0;
        hit = hit && m_cnt >= pers_need[m_cfg[1:0]];
        if (hit) m_active = 0;
        chk(exit_pulse, hit);
        chk(exit_count, m_cnt);
        chk(gesture_active, m_active);
        if (hit) begin
            // Entry attempt during the exit cycle must be ignored
            prox_valid = 1'b1;
            prox_result = 8'hFF;
            tick();
            prox_valid = 1'b0;
            chk(exit_pulse, 0);
            chk(gesture_active, 0);
            tick();
            m_cnt = 0;
            chk(exit_count, 0);
        end
    endtask : gcycle

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog: the run needs a few thousand cycles
    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end

    // ========================================================
    // Main sequence
    initial begin
        srst = 1'b1;
        gesture_en = 1'b1;
        active_clr = 1'b0;
        prox_valid = 1'b0;
        prox_result = 8'h00;
        cycle_valid = 1'b0;
        dir_sample = '0;
        fifo_level = 6'h00;
        irq_en = 1'b0;
        void'($urandom(71473));
        repeat (8) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        u_host.look(gxf_pkg::ADDR_CONFIG_ONE);
        chk(reg_rdata, 0);
        chk({gesture_active, exit_pulse, fifo_irq, exit_count}, 0);
        // Zero exit threshold: no amount of quiet cycles ends the gesture
        wreg(gxf_pkg::ADDR_ENTRY_THR, 8'h20);
        wreg(gxf_pkg::ADDR_CONFIG_ONE, 8'h00);
        wreg(8'h55, 8'hFF);
        enter(8'h1F);
        enter(8'h20);
        repeat (10) gcycle(32'h0000_0000);
        active_clr = 1'b1;
        tick();
        active_clr = 1'b0;
        m_active = 0;
        chk(gesture_active, 0);
        // Dropping the enable leaves the gesture and blocks entry
        enter(8'h20);
        gesture_en = 1'b0;
        tick();
        m_active = 0;
        chk({gesture_active, exit_pulse}, 0);
        enter(8'hFF);
        gesture_en = 1'b1;
        // Every mask and persistence pair with random samples
        wreg(gxf_pkg::ADDR_EXIT_THR, 8'h3C);
        for (int c = 0; c < 64; c++) begin
            wreg(gxf_pkg::ADDR_CONFIG_ONE, {2'($urandom), 6'(c)});
            repeat (8) begin
                while (m_active == 0) enter(8'($urandom_range(24, 64)));
                gcycle($urandom & 32'h1F1F_1F1F);
            end
        end
        // FIFO level interrupt at both sides of each threshold
        for (int sel = 0; sel < 4; sel++) begin
            wreg(gxf_pkg::ADDR_CONFIG_ONE, {2'(sel), 6'h00});
            for (int k = 0; k < 6; k++) begin
                fifo_level = (k < 4) ? 6'(fifo_need[sel] - 1 + k % 2) :
                    6'($urandom_range(0, 32));
                irq_en = (k / 2 != 1);
                tick();
                chk(fifo_irq, irq_en && fifo_level >= fifo_need[sel]);
            end
        end
        report_and_stop();
    end
endmodule : tb_top
